// ### rtl/counter_array_cfg.svh
// Addresses, reset values and field positions of the counter array byte registers.
// Assumes an 8-bit special function register bus that has no paging for these addresses.
//
// Behaviour
// - Count high read returns low-read snapshot
// - Watchdog lock blocks count high writes
// - Low byte address holds value bits 7:0
// - High byte address holds value bits 15:8
// - Reload select steers low byte to reload
// - Reload select steers high byte to reload
// - Low byte write clears comparator enable
// - High byte write sets comparator enable
// - Registers ignore paging and reset to zero
// - Count low holds bits 7:0, locked too
// - Comparator enable arms the match compare
// - Wide select picks 16-bit PWM compare
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH

`define CA_ADDR_COUNT_LOW   8'hF9
`define CA_ADDR_COUNT_HIGH  8'hFA
`define CA_ADDR_M0_LOW      8'hFB
`define CA_ADDR_M0_HIGH     8'hFC
`define CA_ADDR_M1_LOW      8'hE9
`define CA_ADDR_M1_HIGH     8'hEA
`define CA_ADDR_M2_LOW      8'hEB
`define CA_ADDR_M2_HIGH     8'hEC
`define CA_RESET_BYTE       8'h00
`define CA_RESET_WORD       16'h0000
`define CA_UNMAPPED_READ    8'h00
`define CA_PWM_BASE_BITS    8

`endif

// ### rtl/counter_array_pkg.sv
// Types shared by the counter array register files.
// Assumes the constants header is included where numbers are needed.
package counter_array_pkg;
    typedef logic [7:0]  sfr_byte_t;
    typedef logic [15:0] count_word_t;
    typedef logic [1:0]  pwm_extra_t;   // Extra PWM bits above eight: 0..3
endpackage : counter_array_pkg

// ### rtl/module_value_regs.sv
// One capture/compare module: match value, auto-reload value, comparator enable, match.
// Assumes write strobes are already address decoded and qualified by the clock enable.
`include "counter_array_cfg.svh"

module module_value_regs (
    input  wire logic                         mclk,              // System clock
    input  wire logic                         srst,              // Synchronous reset, high
    input  wire logic                         ce,                // Clock enable
    input  wire logic                         wr_low,            // Write to low byte address
    input  wire logic                         wr_high,           // Write to high byte address
    input  wire logic                         reload_select,     // Steer bytes to reload value
    input  wire counter_array_pkg::sfr_byte_t wdata,             // Write data
    input  wire logic                         mode_load,         // Mode register written
    input  wire logic                         mode_enable,       // Comparator enable from mode write
    input  wire counter_array_pkg::count_word_t count,           // Live counter
    input  wire logic                         pwm_enable,        // PWM mode on
    input  wire logic                         wide_pwm_select,   // 16-bit PWM
    input  wire counter_array_pkg::pwm_extra_t pwm_extra,        // PWM width minus eight
    output counter_array_pkg::count_word_t    value,             // Match value
    output counter_array_pkg::count_word_t    reload,            // Auto-reload value
    output logic                              comparator_enable, // Comparator armed
    output logic                              match              // Counter equals value
);
    counter_array_pkg::count_word_t value_r, value_nxt, reload_r, reload_nxt, mask;
    logic cen_r, cen_nxt, match_r, match_nxt;

    // Byte stores, comparator enable side effects and the compare itself
    always_comb begin
        value_nxt  = value_r;
        reload_nxt = reload_r;
        cen_nxt    = cen_r;
        mask       = 16'hFFFF;
        if (mode_load) begin
            cen_nxt = mode_enable;
        end
        if (wr_low) begin
            if (reload_select) reload_nxt[7:0] = wdata;
            else value_nxt[7:0] = wdata;
            cen_nxt = 1'b0;
        end
        if (wr_high) begin
            if (reload_select) reload_nxt[15:8] = wdata;
            else value_nxt[15:8] = wdata;
            cen_nxt = 1'b1;
        end
        // Narrow PWM compares only the active low bits of the counter
        if (pwm_enable && !wide_pwm_select) begin
            mask = 16'(({1'b0, 16'hFFFF} >> (16 - `CA_PWM_BASE_BITS - int'(pwm_extra))));
        end
        match_nxt = cen_r && ((count & mask) == (value_r & mask));
    end

    // Only the registers live here; clock enable freezes them all
    always_ff @(posedge mclk) begin
        if (srst) begin
            value_r  <= `CA_RESET_WORD;
            reload_r <= `CA_RESET_WORD;
            cen_r    <= 1'b0;
            match_r  <= 1'b0;
        end else if (ce) begin
            value_r  <= value_nxt;
            reload_r <= reload_nxt;
            cen_r    <= cen_nxt;
            match_r  <= match_nxt;
        end
    end

    assign value             = value_r;
    assign reload            = reload_r;
    assign comparator_enable = cen_r;
    assign match             = match_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_low_clears_en: assert property (ce && wr_low && !wr_high |=> !comparator_enable)
        else $error("low byte write left comparator enabled");
    a_high_sets_en: assert property (ce && wr_high |=> comparator_enable)
        else $error("high byte write did not enable comparator");
    a_low_target: assert property (ce && wr_low && !reload_select |=> value[7:0] == $past(wdata)
                                   && reload[7:0] == $past(reload[7:0]))
        else $error("low byte write went to wrong store");
    a_high_target: assert property (ce && wr_high && reload_select |=> reload[15:8] == $past(wdata)
                                    && value[15:8] == $past(value[15:8]))
        else $error("high byte write with reload select went to wrong store");
    a_wide_match: assert property (ce && comparator_enable && (!pwm_enable || wide_pwm_select)
                                   && count != value |=> !match)
        else $error("16-bit compare matched unequal values");
    a_disabled_nomatch: assert property (ce && !comparator_enable |=> !match)
        else $error("match raised with comparator disabled");
endmodule : module_value_regs

// ### rtl/counter_array_compare_regs.sv
// Counter array byte registers: 16-bit counter with read snapshot and watchdog lock,
// plus three capture/compare modules behind the special function register bus.
// Assumes single-cycle read and write strobes from the core, synchronous to mclk.
// Assumes the mode register, the watchdog and the PWM outputs live outside; their bits arrive as levels.
// Addresses that belong to no register here read as the unmapped value and ignore writes.
`include "counter_array_cfg.svh"

module counter_array_compare_regs #(
    parameter int N_MODULES = 3                                   // Capture/compare modules
) (
    input  wire logic                          mclk,                // System clock, 100 MHz
    input  wire logic                          srst,                // Synchronous reset, high
    input  wire logic                          ce,                  // Clock enable, freezes all
    input  wire counter_array_pkg::sfr_byte_t  sfr_addr,            // Register address
    input  wire counter_array_pkg::sfr_byte_t  sfr_wdata,           // Write data
    input  wire logic                          sfr_wr,              // Write strobe
    input  wire logic                          sfr_rd,              // Read strobe
    output counter_array_pkg::sfr_byte_t       sfr_rdata,           // Read data, next cycle
    input  wire logic                          count_tick,          // Counter timebase tick
    input  wire logic                          watchdog_lock_enable, // Module 2 watchdog on
    input  wire logic                          reload_select,       // From pwm_config_register
    input  wire counter_array_pkg::pwm_extra_t pwm_extra,           // PWM width minus eight
    input  wire logic [N_MODULES-1:0]          pwm_enable,          // PWM mode per module
    input  wire logic [N_MODULES-1:0]          wide_pwm_select,     // 16-bit PWM per module
    input  wire logic [N_MODULES-1:0]          mode_load,           // Mode register written
    input  wire logic [N_MODULES-1:0]          mode_enable,         // Comparator enable written
    output counter_array_pkg::count_word_t     count,               // Live counter
    output logic [N_MODULES-1:0]               comparator_enable,   // Comparator armed
    output logic [N_MODULES-1:0]               match                // Match per module
);
    localparam logic [7:0] LOW_ADDR  [3] = '{`CA_ADDR_M0_LOW,  `CA_ADDR_M1_LOW,  `CA_ADDR_M2_LOW};
    localparam logic [7:0] HIGH_ADDR [3] = '{`CA_ADDR_M0_HIGH, `CA_ADDR_M1_HIGH, `CA_ADDR_M2_HIGH};

    counter_array_pkg::count_word_t count_r, count_nxt;
    counter_array_pkg::sfr_byte_t   snap_r, snap_nxt, rdata_r, rdata_nxt;
    counter_array_pkg::count_word_t value [N_MODULES];
    counter_array_pkg::count_word_t reload [N_MODULES];
    logic [N_MODULES-1:0] wr_low, wr_high;
    logic rd_low, wr_cnt_low, wr_cnt_high;

    // Address decode; no page qualifier, these addresses answer on every page
    // Reads need no ce here: every register that takes their result is frozen by ce anyway
    assign rd_low      = sfr_rd && sfr_addr == `CA_ADDR_COUNT_LOW;
    assign wr_cnt_low  = ce && sfr_wr && sfr_addr == `CA_ADDR_COUNT_LOW;
    assign wr_cnt_high = ce && sfr_wr && sfr_addr == `CA_ADDR_COUNT_HIGH;

    // Per-module byte stores and comparators
    for (genvar m = 0; m < N_MODULES; m++) begin : g_mod
        assign wr_low[m]  = ce && sfr_wr && sfr_addr == LOW_ADDR[m];
        assign wr_high[m] = ce && sfr_wr && sfr_addr == HIGH_ADDR[m];
        module_value_regs u_mod (
            .mclk              (mclk),
            .srst              (srst),
            .ce                (ce),
            .wr_low            (wr_low[m]),
            .wr_high           (wr_high[m]),
            .reload_select     (reload_select),
            .wdata             (sfr_wdata),
            .mode_load         (mode_load[m]),
            .mode_enable       (mode_enable[m]),
            .count             (count_r),
            .pwm_enable        (pwm_enable[m]),
            .wide_pwm_select   (wide_pwm_select[m]),
            .pwm_extra         (pwm_extra),
            .value             (value[m]),
            .reload            (reload[m]),
            .comparator_enable (comparator_enable[m]),
            .match             (match[m])
        );
    end

    // Counter next value; a software write beats the tick in the same cycle
    // Only the written byte is forced; the other byte still takes the incremented count
    always_comb begin
        count_nxt = count_r;
        if (count_tick) begin
            count_nxt = count_r + 16'h0001;
        end
        // The watchdog owns the counter while it runs, so writes are dropped silently
        if (wr_cnt_low && !watchdog_lock_enable) begin
            count_nxt[7:0] = sfr_wdata;
        end
        if (wr_cnt_high && !watchdog_lock_enable) begin
            count_nxt[15:8] = sfr_wdata;
        end
    end

    // Read path; the snapshot keeps a low-then-high read pair coherent
    // Limitation: a high byte read with no low byte read before it returns a stale snapshot
    always_comb begin
        snap_nxt  = snap_r;
        rdata_nxt = rdata_r;
        if (rd_low) begin
            snap_nxt = count_r[15:8];
        end
        if (sfr_rd) begin
            rdata_nxt = `CA_UNMAPPED_READ;
            if (sfr_addr == `CA_ADDR_COUNT_LOW) rdata_nxt = count_r[7:0];
            if (sfr_addr == `CA_ADDR_COUNT_HIGH) rdata_nxt = snap_r;
            for (int m = 0; m < N_MODULES; m++) begin
                if (sfr_addr == LOW_ADDR[m]) begin
                    rdata_nxt = reload_select ? reload[m][7:0] : value[m][7:0];
                end
                if (sfr_addr == HIGH_ADDR[m]) begin
                    rdata_nxt = reload_select ? reload[m][15:8] : value[m][15:8];
                end
            end
        end
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_r <= `CA_RESET_WORD;
            snap_r  <= `CA_RESET_BYTE;
            rdata_r <= `CA_RESET_BYTE;
        end else if (ce) begin
            count_r <= count_nxt;
            snap_r  <= snap_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign count     = count_r;
    assign sfr_rdata = rdata_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_read_low;
        ce && sfr_rd && sfr_addr == `CA_ADDR_COUNT_LOW;
    endsequence
    sequence s_read_high;
        ce && sfr_rd && sfr_addr == `CA_ADDR_COUNT_HIGH;
    endsequence
    sequence s_read_pair;
        s_read_low ##1 s_read_high;
    endsequence

    a_snapshot_pair: assert property (s_read_pair |=> sfr_rdata == $past(count_r[15:8], 2))
        else $error("high byte read did not return snapshot");
    a_high_lock: assert property (wr_cnt_high && watchdog_lock_enable && !count_tick
                                  |=> count_r == $past(count_r))
        else $error("locked counter high byte was written");
    a_low_lock: assert property (wr_cnt_low && watchdog_lock_enable && !count_tick
                                 |=> count_r == $past(count_r))
        else $error("locked counter low byte was written");
    a_high_write: assert property (wr_cnt_high && !watchdog_lock_enable |=> count_r[15:8] == $past(sfr_wdata))
        else $error("unlocked counter high write lost");
    a_value_read: assert property (ce && sfr_rd && sfr_addr == `CA_ADDR_M0_HIGH && !reload_select
                                   |=> sfr_rdata == $past(value[0][15:8]))
        else $error("module 0 high byte read wrong");
    a_reload_read: assert property (ce && sfr_rd && sfr_addr == `CA_ADDR_M1_LOW && reload_select
                                    |=> sfr_rdata == $past(reload[1][7:0]))
        else $error("module 1 reload low read wrong");
    a_reset_zero: assert property (@(posedge mclk) disable iff (1'b0) srst |=> count_r == `CA_RESET_WORD
                                   && sfr_rdata == `CA_RESET_BYTE && comparator_enable == '0)
        else $error("reset did not clear registers");

    // Snapshot: loaded by a taken low byte read, untouched otherwise, served by the high byte address
    a_snap_load: assert property (ce && rd_low |=> snap_r == $past(count_r[15:8]))
        else $error("low byte read did not load the snapshot");
    a_snap_hold: assert property (!(ce && rd_low) |=> snap_r == $past(snap_r))
        else $error("snapshot moved without a low byte read");
    a_high_read: assert property (ce && sfr_rd && sfr_addr == `CA_ADDR_COUNT_HIGH
                                  |=> sfr_rdata == $past(snap_r))
        else $error("high byte read did not return the snapshot");

    // Counter: the low byte reads live, unlocked writes land, otherwise it steps or stands
    a_low_read: assert property (ce && sfr_rd && sfr_addr == `CA_ADDR_COUNT_LOW
                                 |=> sfr_rdata == $past(count_r[7:0]))
        else $error("low byte read did not return the live count");
    a_low_write: assert property (wr_cnt_low && !watchdog_lock_enable |=> count_r[7:0] == $past(sfr_wdata))
        else $error("unlocked counter low write lost");
    a_count_step: assert property (ce && count_tick && !wr_cnt_low && !wr_cnt_high
                                   |=> count_r == $past(count_r) + 16'h0001)
        else $error("counter did not step on a tick");
    a_count_hold: assert property (ce && !count_tick && !wr_cnt_low && !wr_cnt_high
                                   |=> count_r == $past(count_r))
        else $error("counter moved with no tick and no write");

    // Read data stands until the next taken read
    a_rdata_hold: assert property (!(ce && sfr_rd) |=> sfr_rdata == $past(sfr_rdata))
        else $error("read data changed without a taken read");

    // Any address of this block; a read anywhere else must give the unmapped value
    logic addr_mapped;
    always_comb begin
        addr_mapped = sfr_addr == `CA_ADDR_COUNT_LOW || sfr_addr == `CA_ADDR_COUNT_HIGH;
        for (int m = 0; m < N_MODULES; m++) begin
            if (sfr_addr == LOW_ADDR[m] || sfr_addr == HIGH_ADDR[m]) begin
                addr_mapped = 1'b1;
            end
        end
    end
    a_unmapped_read: assert property (ce && sfr_rd && !addr_mapped |=> sfr_rdata == `CA_UNMAPPED_READ)
        else $error("unmapped address did not read the unmapped value");

    // Per-module checks at the bus: read steering and the write side effects on the enable
    for (genvar m = 0; m < N_MODULES; m++) begin : g_chk
        a_mod_low_value: assert property (ce && sfr_rd && sfr_addr == LOW_ADDR[m] && !reload_select
                                          |=> sfr_rdata == $past(value[m][7:0]))
            else $error("module low byte read did not return the match value");
        a_mod_high_value: assert property (ce && sfr_rd && sfr_addr == HIGH_ADDR[m] && !reload_select
                                           |=> sfr_rdata == $past(value[m][15:8]))
            else $error("module high byte read did not return the match value");
        a_mod_low_reload: assert property (ce && sfr_rd && sfr_addr == LOW_ADDR[m] && reload_select
                                           |=> sfr_rdata == $past(reload[m][7:0]))
            else $error("module low byte read did not return the reload value");
        a_mod_high_reload: assert property (ce && sfr_rd && sfr_addr == HIGH_ADDR[m] && reload_select
                                            |=> sfr_rdata == $past(reload[m][15:8]))
            else $error("module high byte read did not return the reload value");
        a_bus_low_clear: assert property (wr_low[m] |=> !comparator_enable[m])
            else $error("low byte write left the comparator enabled");
        a_bus_high_set: assert property (wr_high[m] |=> comparator_enable[m])
            else $error("high byte write did not enable the comparator");
    end

    a_freeze: assert property (!ce |=> count_r == $past(count_r) && sfr_rdata == $past(sfr_rdata))
        else $error("state moved with clock enable low");
endmodule : counter_array_compare_regs

// ### test/sfr_master.sv
// Behavioural model of the processor core on the register bus.
// Assumes the block samples strobes on the rising edge of mclk; this model drives on the falling edge.
`include "counter_array_cfg.svh"

module sfr_master (
    input  wire logic                         mclk,  // System clock
    output counter_array_pkg::sfr_byte_t      addr,  // Register address
    output counter_array_pkg::sfr_byte_t      wdata, // Write data
    output logic                              wr,    // Write strobe
    output logic                              rd,    // Read strobe
    input  wire counter_array_pkg::sfr_byte_t rdata  // Read data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle strobe; idle address and data flip so stale values never pass for valid ones
    task automatic write_byte(input counter_array_pkg::sfr_byte_t a, input counter_array_pkg::sfr_byte_t d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : write_byte

    // Read data shows at the taken edge and is sampled half a cycle later, on the falling edge
    task automatic read_byte(input counter_array_pkg::sfr_byte_t a, output counter_array_pkg::sfr_byte_t d);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask : read_byte

    // Low byte first and back to back, so the high byte comes from the snapshot of the same instant
    task automatic read_count(output counter_array_pkg::count_word_t c);
        @(negedge mclk);
        addr = `CA_ADDR_COUNT_LOW;
        rd = 1'b1;
        @(negedge mclk);
        c[7:0] = rdata;
        addr = `CA_ADDR_COUNT_HIGH;
        @(negedge mclk);
        c[15:8] = rdata;
        rd = 1'b0;
        addr = ~`CA_ADDR_COUNT_HIGH;
    endtask : read_count
endmodule : sfr_master

// ### test/counter_array_compare_regs_bench.sv
// Self-checking bench for the counter array byte registers.
// Assumes the core model in sfr_master.sv drives the register bus.
`include "counter_array_cfg.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module counter_array_compare_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, tick = 1'b0, lock = 1'b0, rsel = 1'b0;
    logic sfr_wr, sfr_rd;
    counter_array_pkg::sfr_byte_t    addr, wdata, rdata, rb;
    counter_array_pkg::pwm_extra_t   pwm_extra = 2'h0;
    logic [2:0]                      pwm_en = 3'h0, wide = 3'h0, en, match;
    logic [2:0]                      mode_ld = 3'h0, mode_en = 3'h0;
    counter_array_pkg::count_word_t  count, cw;
    int err_count = 0;
    int checks = 0;
    counter_array_pkg::sfr_byte_t lo_a[3] = '{`CA_ADDR_M0_LOW, `CA_ADDR_M1_LOW, `CA_ADDR_M2_LOW};
    counter_array_pkg::sfr_byte_t hi_a[3] = '{`CA_ADDR_M0_HIGH, `CA_ADDR_M1_HIGH, `CA_ADDR_M2_HIGH};

    sfr_master core_u (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(sfr_wr), .rd(sfr_rd), .rdata(rdata));

    counter_array_compare_regs #(.N_MODULES(3)) dut_u (
        .mclk(mclk), .srst(srst), .ce(ce), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(rdata), .count_tick(tick), .watchdog_lock_enable(lock),
        .reload_select(rsel), .pwm_extra(pwm_extra), .pwm_enable(pwm_en), .wide_pwm_select(wide),
        .mode_load(mode_ld), .mode_enable(mode_en), .count(count), .comparator_enable(en), .match(match));

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic finish_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Every address reads zero after reset; strobes are ignored while ce is low
    task automatic test_reset;
        for (int i = 0; i < 3; i++) begin
            core_u.read_byte(lo_a[i], rb); `CHK(rb, 8'h00)
            core_u.read_byte(hi_a[i], rb); `CHK(rb, 8'h00)
        end
        core_u.read_count(cw); `CHK(cw, 16'h0000)
        @(negedge mclk) ce = 1'b0;
        core_u.write_byte(8'hFC, 8'hAA);
        @(negedge mclk) ce = 1'b1;
        core_u.read_byte(8'hFC, rb); `CHK(rb, 8'h00)
        `CHK(en, 3'h0)
        $display("test_reset done");
    endtask : test_reset

    // High byte reads come from the snapshot taken at the low byte read
    task automatic test_snapshot;
        core_u.write_byte(8'hFA, 8'h12);
        core_u.write_byte(8'hF9, 8'h34);
        `CHK(count, 16'h1234)
        core_u.read_count(cw); `CHK(cw, 16'h1234)
        core_u.write_byte(8'hFA, 8'h56);
        core_u.read_byte(8'hFA, rb); `CHK(rb, 8'h12)
        core_u.read_count(cw); `CHK(cw, 16'h5634)
        $display("test_snapshot done");
    endtask : test_snapshot

    // Counter writes are dropped under the watchdog lock; ticks then count with the lock off
    task automatic test_lock;
        @(negedge mclk) lock = 1'b1;
        core_u.write_byte(8'hF9, 8'hAB);
        core_u.write_byte(8'hFA, 8'hCD);
        `CHK(count, 16'h5634)
        lock = 1'b0;
        tick = 1'b1;
        repeat (4) @(negedge mclk);
        tick = 1'b0;
        `CHK(count, 16'h5638)
        $display("test_lock done");
    endtask : test_lock

    // High byte write arms the comparator, low byte write disarms it, per module
    task automatic test_modules;
        for (int m = 0; m < 3; m++) begin
            core_u.write_byte(hi_a[m], 8'hA0 + 8'(m)); `CHK(en[m], 1'b1)
            core_u.write_byte(lo_a[m], 8'h50 + 8'(m)); `CHK(en[m], 1'b0)
            core_u.read_byte(hi_a[m], rb); `CHK(rb, 8'hA0 + 8'(m))
            core_u.read_byte(lo_a[m], rb); `CHK(rb, 8'h50 + 8'(m))
        end
        $display("test_modules done");
    endtask : test_modules

    // Reload select steers both byte addresses; enable side effects still apply
    task automatic test_reload;
        @(negedge mclk) rsel = 1'b1;
        core_u.write_byte(8'hFB, 8'h11); `CHK(en[0], 1'b0)
        core_u.write_byte(8'hFC, 8'h22); `CHK(en[0], 1'b1)
        core_u.read_byte(8'hFB, rb); `CHK(rb, 8'h11)
        core_u.read_byte(8'hFC, rb); `CHK(rb, 8'h22)
        core_u.write_byte(8'hE9, 8'h77);
        core_u.read_byte(8'hE9, rb); `CHK(rb, 8'h77)
        rsel = 1'b0;
        core_u.read_byte(8'hFB, rb); `CHK(rb, 8'h50)
        core_u.read_byte(8'hFC, rb); `CHK(rb, 8'hA0)
        core_u.read_byte(8'hE9, rb); `CHK(rb, 8'h51)
        core_u.read_byte(8'hF8, rb); `CHK(rb, `CA_UNMAPPED_READ)
        $display("test_reload done");
    endtask : test_reload

    // Match needs the enable; narrow PWM compares only the low bits
    task automatic test_match;
        core_u.write_byte(8'hE9, 8'h38);
        core_u.write_byte(8'hEA, 8'h56);
        repeat (2) @(negedge mclk); `CHK(match[1], 1'b1)
        core_u.write_byte(8'hE9, 8'h38);
        repeat (2) @(negedge mclk); `CHK(match[1], 1'b0)
        pwm_en = 3'h4;
        core_u.write_byte(8'hEB, 8'h38);
        core_u.write_byte(8'hEC, 8'h99);
        repeat (2) @(negedge mclk); `CHK(match[2], 1'b1)
        wide = 3'h4;
        repeat (2) @(negedge mclk); `CHK(match[2], 1'b0)
        wide = 3'h0;
        pwm_extra = 2'h1;
        repeat (2) @(negedge mclk); `CHK(match[2], 1'b0)
        mode_en = 3'h2;
        mode_ld = 3'h2;
        @(negedge mclk) mode_ld = 3'h0;
        `CHK(en[1], 1'b1)
        repeat (2) @(negedge mclk); `CHK(match[1], 1'b1)
        $display("test_match done");
    endtask : test_match

    // Reset in mid-run clears the counter, every store, the snapshot and the enables
    task automatic test_midreset;
        @(negedge mclk) srst = 1'b1;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        `CHK(count, 16'h0000)
        `CHK(en, 3'h0)
        `CHK(match, 3'h0)
        core_u.read_byte(8'hFA, rb); `CHK(rb, 8'h00)
        for (int s = 0; s < 2; s++) begin
            rsel = 1'(s);
            for (int i = 0; i < 3; i++) begin
                core_u.read_byte(lo_a[i], rb); `CHK(rb, 8'h00)
                core_u.read_byte(hi_a[i], rb); `CHK(rb, 8'h00)
            end
        end
        rsel = 1'b0;
        $display("test_midreset done");
    endtask : test_midreset

    // Hold reset five cycles, then run the scenarios
    initial begin
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        test_reset();
        test_snapshot();
        test_lock();
        test_modules();
        test_reload();
        test_match();
        test_midreset();
        finish_test();
    end

    // Scenarios take under two hundred cycles; this cuts a hang short
    initial begin
        #50000;
        err_count++;
        finish_test();
    end
endmodule : counter_array_compare_regs_bench
